// [common/zcb_params.svh]
`ifndef ZCB_PARAMS_SVH
`define ZCB_PARAMS_SVH

// Instruction word width and opcode values (upper six bits)
`define ZCB_IW              32
`define ZCB_OPC_REG         6'h27
`define ZCB_OPC_IMM         6'h2F

// Condition codes held in the four bits after the delay flag
`define ZCB_CC_EQ           4'h0
`define ZCB_CC_GE           4'h5
`define ZCB_CC_GT           4'h4

// Field positions, counted from bit 0 at the word's most significant end
`define ZCB_DOC_DELAY_POS   6
`define ZCB_DOC_CMP_POS     11
`define ZCB_DOC_OFF_POS     16
`define ZCB_DELAY_BIT       (31 - `ZCB_DOC_DELAY_POS)
`define ZCB_CC_MSB          (`ZCB_DELAY_BIT - 1)
`define ZCB_CMP_MSB         (31 - `ZCB_DOC_CMP_POS)
`define ZCB_OFF_MSB         (31 - `ZCB_DOC_OFF_POS)
`define ZCB_IMM_W           16

// Sequential step and cycle costs
`define ZCB_PC_STEP         32'h0000_0004
`define ZCB_COST_FALSE      4'h1
`define ZCB_COST_PRED_OK    4'h1
`define ZCB_COST_SLOT       4'h2
`define ZCB_COST_NOSLOT     4'h3
`define ZCB_COST_SLOT_A2    4'h6
`define ZCB_COST_NOSLOT_A2  4'h7
`define ZCB_COST_MISS_A0    4'h3
`define ZCB_COST_MISS_A2    4'h7
`define ZCB_COST_MMU_EXTRA  4'h2
`define ZCB_AREA_FULL       2'h2
`define ZCB_MMU_THRESHOLD   2'h1

// Register offsets (byte addresses) and field positions
`define ZCB_REG_CTRL        12'h000
`define ZCB_REG_STATUS      12'h004
`define ZCB_REG_TARGET      12'h008
`define ZCB_REG_COUNT       12'h00C
`define ZCB_CTRL_AREA_LSB   0
`define ZCB_CTRL_MMU_LSB    4
`define ZCB_ST_BUSY         0
`define ZCB_ST_TAKEN        1
`define ZCB_ST_DELAY        2
`define ZCB_ST_MISS         3
`define ZCB_ST_UNSUP        4
`define ZCB_ST_COST_LSB     8

`endif

// [common/zcb_pkg.sv]
package zcb_pkg;

    // Decoded branch operation
    typedef enum logic [1:0] {
        ZCB_OP_NONE,
        ZCB_OP_EQ,
        ZCB_OP_GE,
        ZCB_OP_GT
    } zcb_op_t;

    // Sequencer states
    typedef enum logic {
        ZCB_IDLE,
        ZCB_EXEC
    } zcb_fsm_t;

    // One instruction offered for execution
    typedef struct packed {
        logic        valid;
        logic [31:0] instr;
        logic [31:0] pc;
        logic [31:0] cmp_val;
        logic [31:0] off_val;
        logic        prefix_valid;
        logic [15:0] prefix_hi;
        logic        pred_valid;
        logic        pred_taken;
    } zcb_issue_t;

    // Outcome of one branch
    typedef struct packed {
        logic        valid;
        logic        taken;
        logic        delay;
        logic        slot_keep;
        logic        slot_flush;
        logic        unsupported;
        logic        mispredict;
        logic        imm_form;
        zcb_op_t     op;
        logic [4:0]  cmp_index;
        logic [4:0]  off_index;
        logic [3:0]  cost;
        logic [31:0] next_pc;
    } zcb_result_t;

    // APB request from the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } zcb_apb_req_t;

    // APB answer to the master
    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } zcb_apb_rsp_t;

    // Whole state of the branch unit
    typedef struct packed {
        zcb_fsm_t     fsm;
        logic         ready;
        logic [3:0]   cnt;
        logic [1:0]   area;
        logic [1:0]   mmu;
        zcb_result_t  res;
        logic [31:0]  cap_pc;
        logic [31:0]  cap_cmp;
        logic [31:0]  cap_off;
        logic [31:0]  taken_cnt;
        zcb_apb_rsp_t apb;
    } zcb_state_t;

endpackage

// [core/zcb_cond_eval.sv]
`include "zcb_params.svh"

// Pure decode, condition test and target arithmetic
module zcb_cond_eval (
    // Instruction and operands
    input  logic [31:0]      instr,
    input  logic [31:0]      pc,
    input  logic [31:0]      cmp_val,
    input  logic [31:0]      off_val,
    input  logic             prefix_valid,
    input  logic [15:0]      prefix_hi,
    // Decoded view
    output zcb_pkg::zcb_op_t op,
    output logic             delay,
    output logic             imm_form,
    output logic [4:0]       cmp_index,
    output logic [4:0]       off_index,
    // Outcome
    output logic             taken,
    output logic [31:0]      offset,
    output logic [31:0]      next_pc
);

    logic [3:0] cc;     // Condition code field
    logic       is_reg; // Register-offset opcode
    logic       is_imm; // Immediate-offset opcode

    // Decode opcode and fields
    always_comb begin
        is_reg    = (instr[31:26] == `ZCB_OPC_REG) && (instr[10:0] == 11'h000);
        is_imm    = (instr[31:26] == `ZCB_OPC_IMM);
        cc        = instr[`ZCB_CC_MSB -: 4];
        // RL9 delay and fields
        delay     = instr[`ZCB_DELAY_BIT];
        cmp_index = instr[`ZCB_CMP_MSB -: 5];
        off_index = instr[`ZCB_OFF_MSB -: 5];
        imm_form  = is_imm;
        op        = zcb_pkg::ZCB_OP_NONE;
        if (is_reg || is_imm) begin
            case (cc)
                `ZCB_CC_EQ: op = zcb_pkg::ZCB_OP_EQ;
                `ZCB_CC_GE: op = zcb_pkg::ZCB_OP_GE;
                // Greater-than is only handled in register form here
                `ZCB_CC_GT: op = is_reg ? zcb_pkg::ZCB_OP_GT : zcb_pkg::ZCB_OP_NONE;
                default:    op = zcb_pkg::ZCB_OP_NONE;
            endcase
        end
    end

    // Condition test on the compare source
    always_comb begin
        case (op)
            // RL1 exact zero test
            zcb_pkg::ZCB_OP_EQ: taken = (cmp_val == 32'h0000_0000);
            // RL2 RL18 signed non-negative
            zcb_pkg::ZCB_OP_GE: taken = ($signed(cmp_val) >= 0);
            // RL3 RL18 signed positive
            zcb_pkg::ZCB_OP_GT: taken = ($signed(cmp_val) > 0);
            default:            taken = 1'b0;
        endcase
    end

    // Offset selection and next program counter
    always_comb begin
        if (!imm_form) begin
            // RL4 full register offset
            offset = off_val;
        end else if (prefix_valid) begin
            // RL17 prefix gives full offset
            offset = {prefix_hi, instr[`ZCB_IMM_W-1:0]};
        end else begin
            // RL5 sign-extended literal
            offset = {{16{instr[`ZCB_IMM_W-1]}}, instr[`ZCB_IMM_W-1:0]};
        end
        // RL6 sequential step otherwise
        next_pc = taken ? (pc + offset) : (pc + `ZCB_PC_STEP);
    end

endmodule

// [core/zcb_branch_unit.sv]
// Function
// RL1 - Equal branch taken only on zero
// RL2 - Greater-or-equal taken when source non-negative
// RL3 - Greater-than register form needs positive source
// RL4 - Register form target: pc plus register
// RL5 - Immediate form target: pc plus sign-extended literal
// RL6 - False condition steps pc by four
// RL7 - Delay flag lets following instruction complete
// RL8 - No delay flag: target runs next
// RL9 - Delay bit 6, fields at 11, 16
// RL10 - False condition costs one cycle
// RL11 - Taken with slot costs two cycles
// RL12 - Taken without slot costs three cycles
// RL13 - Full area level costs six or seven
// RL14 - Full area with MMU above one adds two
// RL15 - Correct immediate prediction costs one cycle
// RL16 - Immediate mispredict costs three or seven
// RL17 - Prefix makes immediate offset full width
// RL18 - Compare source is signed two's complement
// RL19 - Only program counter changes, nothing else
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`include "zcb_params.svh"

module zcb_branch_unit #(
    parameter logic [1:0] AREA_LEVEL = 2'h0,  // Reset area optimisation level
    parameter logic [1:0] MMU_CONFIG = 2'h0   // Reset memory management config
) (
    // Clock and reset
    input  logic                 clk,
    input  logic                 reset,
    // Instruction issue
    input  zcb_pkg::zcb_issue_t  issue,
    output logic                 issue_ready,
    // Branch outcome
    output zcb_pkg::zcb_result_t res,
    // Register bus
    input  zcb_pkg::zcb_apb_req_t apb_req,
    output zcb_pkg::zcb_apb_rsp_t apb_rsp
);

    zcb_pkg::zcb_state_t s_r;    // Registered state
    zcb_pkg::zcb_state_t s_nxt;  // Next state

    zcb_pkg::zcb_op_t    dec_op;       // Decoded operation
    logic                dec_delay;    // Delay flag
    logic                dec_imm;      // Immediate form
    logic [4:0]          dec_cmp_idx;  // Compare source index
    logic [4:0]          dec_off_idx;  // Offset source index
    logic                dec_taken;    // Condition outcome
    logic [31:0]         dec_offset;   // Effective offset
    logic [31:0]         dec_next_pc;  // Next pc
    logic                accept;       // Issue taken this cycle
    logic                pred_used;    // Prediction applies
    logic                miss;         // Prediction was wrong
    logic [3:0]          cost;         // Cycles for this branch
    logic                apb_done;     // Access phase completes

    // Cycle cost of one branch
    function automatic logic [3:0] branch_cost(
        input logic       taken,
        input logic       delay,
        input logic       pred_on,
        input logic       pred_ok,
        input logic [1:0] area,
        input logic [1:0] mmu
    );
        logic [3:0] base;
        logic       full;
        full = (area == `ZCB_AREA_FULL);
        base = `ZCB_COST_FALSE;
        if (pred_on && pred_ok) begin
            // RL15 correct prediction
            return `ZCB_COST_PRED_OK;
        end else if (pred_on) begin
            // RL16 mispredict penalty
            base = full ? `ZCB_COST_MISS_A2 : `ZCB_COST_MISS_A0;
        end else if (!taken) begin
            // RL10 false costs one
            return `ZCB_COST_FALSE;
        end else if (full) begin
            // RL13 full area costs
            base = delay ? `ZCB_COST_SLOT_A2 : `ZCB_COST_NOSLOT_A2;
        end else begin
            // RL11 RL12 taken costs
            base = delay ? `ZCB_COST_SLOT : `ZCB_COST_NOSLOT;
        end
        // RL14 memory management extra
        if (full && (mmu > `ZCB_MMU_THRESHOLD)) begin
            base = base + `ZCB_COST_MMU_EXTRA;
        end
        return base;
    endfunction

    // Register read mux
    function automatic logic [31:0] reg_read(
        input zcb_pkg::zcb_state_t st,
        input logic [11:0]         addr
    );
        logic [31:0] d;
        d = 32'h0000_0000;
        case (addr)
            `ZCB_REG_CTRL: begin
                d[`ZCB_CTRL_AREA_LSB +: 2] = st.area;
                d[`ZCB_CTRL_MMU_LSB +: 2]  = st.mmu;
            end
            `ZCB_REG_STATUS: begin
                d[`ZCB_ST_BUSY]          = (st.fsm == zcb_pkg::ZCB_EXEC);
                d[`ZCB_ST_TAKEN]         = st.res.taken;
                d[`ZCB_ST_DELAY]         = st.res.delay;
                d[`ZCB_ST_MISS]          = st.res.mispredict;
                d[`ZCB_ST_UNSUP]         = st.res.unsupported;
                d[`ZCB_ST_COST_LSB +: 4] = st.res.cost;
            end
            `ZCB_REG_TARGET: d = st.res.next_pc;
            `ZCB_REG_COUNT:  d = st.taken_cnt;
            default:         d = 32'h0000_0000;
        endcase
        return d;
    endfunction

    // Decode and arithmetic
    zcb_cond_eval u_eval (
        .instr        (issue.instr),
        .pc           (issue.pc),
        .cmp_val      (issue.cmp_val),
        .off_val      (issue.off_val),
        .prefix_valid (issue.prefix_valid),
        .prefix_hi    (issue.prefix_hi),
        .op           (dec_op),
        .delay        (dec_delay),
        .imm_form     (dec_imm),
        .cmp_index    (dec_cmp_idx),
        .off_index    (dec_off_idx),
        .taken        (dec_taken),
        .offset       (dec_offset),
        .next_pc      (dec_next_pc)
    );

    // Issue handshake and cost terms
    always_comb begin
        accept    = issue.valid && s_r.ready;
        pred_used = dec_imm && issue.pred_valid && (dec_op != zcb_pkg::ZCB_OP_NONE);
        miss      = pred_used && (issue.pred_taken != dec_taken);
        cost      = branch_cost(dec_taken, dec_delay, pred_used, !miss, s_r.area, s_r.mmu);
        apb_done  = apb_req.psel && apb_req.penable && s_r.apb.pready;
    end

    // Next-state logic
    always_comb begin
        s_nxt           = s_r;
        s_nxt.res.valid = 1'b0;
        s_nxt.apb       = '0;
        // Setup phase prepares a zero-wait answer
        if (apb_req.psel && !apb_req.penable) begin
            s_nxt.apb.pready  = 1'b1;
            s_nxt.apb.prdata  = reg_read(s_r, apb_req.paddr);
            s_nxt.apb.pslverr = !(apb_req.paddr == `ZCB_REG_CTRL || apb_req.paddr == `ZCB_REG_STATUS ||
                                  apb_req.paddr == `ZCB_REG_TARGET || apb_req.paddr == `ZCB_REG_COUNT);
        end
        // Writes land only at the completing edge
        if (apb_done && apb_req.pwrite && apb_req.paddr == `ZCB_REG_CTRL) begin
            s_nxt.area = apb_req.pwdata[`ZCB_CTRL_AREA_LSB +: 2];
            s_nxt.mmu  = apb_req.pwdata[`ZCB_CTRL_MMU_LSB +: 2];
        end
        case (s_r.fsm)
            zcb_pkg::ZCB_IDLE: begin
                if (accept) begin
                    // Capture outcome; it is released after its cost
                    s_nxt.cap_pc          = issue.pc;
                    s_nxt.cap_cmp         = issue.cmp_val;
                    s_nxt.cap_off         = dec_offset;
                    s_nxt.res.op          = dec_op;
                    s_nxt.res.imm_form    = dec_imm;
                    s_nxt.res.delay       = dec_delay;
                    s_nxt.res.cmp_index   = dec_cmp_idx;
                    s_nxt.res.off_index   = dec_off_idx;
                    s_nxt.res.unsupported = (dec_op == zcb_pkg::ZCB_OP_NONE);
                    s_nxt.res.taken       = dec_taken;
                    s_nxt.res.mispredict  = miss;
                    s_nxt.res.next_pc     = dec_next_pc;
                    // RL7 slot instruction completes
                    s_nxt.res.slot_keep   = dec_taken && dec_delay;
                    // RL8 following instruction squashed
                    s_nxt.res.slot_flush  = dec_taken && !dec_delay;
                    s_nxt.res.cost        = cost;
                    s_nxt.cnt             = cost - 4'h1;
                    if (cost == 4'h1) begin
                        // Single-cycle outcome, stay ready
                        s_nxt.res.valid = 1'b1;
                        s_nxt.taken_cnt = s_r.taken_cnt + {31'h0000_0000, dec_taken};
                    end else begin
                        // Longer cost stalls the issue port
                        s_nxt.ready = 1'b0;
                        s_nxt.fsm   = zcb_pkg::ZCB_EXEC;
                    end
                end
            end
            zcb_pkg::ZCB_EXEC: begin
                s_nxt.cnt = s_r.cnt - 4'h1;
                if (s_r.cnt == 4'h1) begin
                    s_nxt.res.valid = 1'b1;
                    s_nxt.taken_cnt = s_r.taken_cnt + {31'h0000_0000, s_r.res.taken};
                    s_nxt.ready     = 1'b1;
                    s_nxt.fsm       = zcb_pkg::ZCB_IDLE;
                end
            end
            default: begin
                s_nxt.fsm   = zcb_pkg::ZCB_IDLE;
                s_nxt.ready = 1'b1;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_r       <= '0;
            s_r.fsm   <= zcb_pkg::ZCB_IDLE;
            s_r.ready <= 1'b1;
            s_r.area  <= AREA_LEVEL;
            s_r.mmu   <= MMU_CONFIG;
        end else begin
            s_r <= s_nxt;
        end
    end

    // RL19 no register writeback
    // The unit owns no register or flag write port; only issue_ready, the outcome in res, next_pc included, and the APB answer leave it
    always_comb begin
        issue_ready = s_r.ready;
        res         = s_r.res;
        apb_rsp     = s_r.apb;
    end

    // Checks on each released outcome
    property p_eq_zero;
        @(posedge clk) disable iff (reset)
        (s_r.res.valid && s_r.res.op == zcb_pkg::ZCB_OP_EQ) |-> (s_r.res.taken == (s_r.cap_cmp == 32'h0));
    endproperty
    a_eq_zero: assert property (p_eq_zero) else $error("equal branch outcome wrong"); // RL1

    property p_ge_zero;
        @(posedge clk) disable iff (reset)
        (s_r.res.valid && s_r.res.op == zcb_pkg::ZCB_OP_GE) |-> (s_r.res.taken == !s_r.cap_cmp[31]);
    endproperty
    a_ge_zero: assert property (p_ge_zero) else $error("greater-or-equal outcome wrong"); // RL2

    property p_gt_zero;
        @(posedge clk) disable iff (reset)
        (s_r.res.valid && s_r.res.op == zcb_pkg::ZCB_OP_GT)
            |-> (s_r.res.taken == (!s_r.cap_cmp[31] && s_r.cap_cmp != 32'h0));
    endproperty
    a_gt_zero: assert property (p_gt_zero) else $error("greater-than outcome wrong"); // RL3

    property p_taken_target;
        @(posedge clk) disable iff (reset)
        (s_r.res.valid && s_r.res.taken) |-> (s_r.res.next_pc == s_r.cap_pc + s_r.cap_off);
    endproperty
    a_taken_target: assert property (p_taken_target) else $error("taken target wrong"); // RL4

    property p_seq_step;
        @(posedge clk) disable iff (reset)
        (s_r.res.valid && !s_r.res.taken) |-> (s_r.res.next_pc == s_r.cap_pc + 32'h4);
    endproperty
    a_seq_step: assert property (p_seq_step) else $error("sequential pc wrong"); // RL6

    property p_slot;
        @(posedge clk) disable iff (reset)
        s_r.res.valid |-> (s_r.res.slot_keep == (s_r.res.taken && s_r.res.delay)) &&
                          (s_r.res.slot_flush == (s_r.res.taken && !s_r.res.delay));
    endproperty
    a_slot: assert property (p_slot) else $error("delay slot handling wrong"); // RL7

    property p_false_cost;
        @(posedge clk) disable iff (reset)
        (accept && !dec_taken && !pred_used) |=> (s_r.res.valid && s_r.res.cost == 4'h1);
    endproperty
    a_false_cost: assert property (p_false_cost) else $error("false branch not one cycle"); // RL10

    property p_slot_cost;
        @(posedge clk) disable iff (reset)
        (accept && dec_taken && dec_delay && !pred_used && s_r.area != 2'h2)
            |=> !s_r.res.valid ##1 s_r.res.valid;
    endproperty
    a_slot_cost: assert property (p_slot_cost) else $error("slot branch not two cycles"); // RL11

    property p_noslot_cost;
        @(posedge clk) disable iff (reset)
        (accept && dec_taken && !dec_delay && !pred_used && s_r.area != 2'h2)
            |=> !s_r.res.valid [*2] ##1 s_r.res.valid;
    endproperty
    a_noslot_cost: assert property (p_noslot_cost) else $error("no-slot branch not three cycles"); // RL12

    property p_full_area_cost;
        @(posedge clk) disable iff (reset)
        (s_r.res.valid && s_r.res.taken && !s_r.res.imm_form && s_r.area == 2'h2 && s_r.mmu <= 2'h1)
            |-> (s_r.res.cost == (s_r.res.delay ? 4'h6 : 4'h7));
    endproperty
    a_full_area_cost: assert property (p_full_area_cost) else $error("full area cost wrong"); // RL13

    property p_pred_ok;
        @(posedge clk) disable iff (reset)
        (accept && pred_used && !miss) |=> (s_r.res.valid && s_r.res.cost == 4'h1);
    endproperty
    a_pred_ok: assert property (p_pred_ok) else $error("predicted branch not one cycle"); // RL15

endmodule

// [tb/test_zero_compare_branch_unit.sv]
`include "zcb_params.svh"

module test_zero_compare_branch_unit;
    timeunit 1ns;
    timeprecision 1ps;

    // Clock and reset
    logic                  clk;
    logic                  reset;
    // Design ports
    zcb_pkg::zcb_issue_t   issue;
    logic                  issue_ready;
    zcb_pkg::zcb_result_t  res;
    zcb_pkg::zcb_apb_req_t apb_req;
    zcb_pkg::zcb_apb_rsp_t apb_rsp;
    // Bench bookkeeping
    int                    fails;
    int                    checks_done;
    int                    cycles;
    logic [1:0]            area;
    logic [1:0]            mmu;
    logic [31:0]           n_taken;
    logic [31:0]           last_status;
    logic [31:0]           last_pc;
    logic [31:0]           rd;
    logic                  err;
    // Configurations: both area extremes, MMU extra only at full area
    logic [1:0]            area_t [5] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h0};
    logic [1:0]            mmu_t  [5] = '{2'h0, 2'h0, 2'h0, 2'h2, 2'h3};

    zcb_branch_unit #(.AREA_LEVEL(2'h0), .MMU_CONFIG(2'h0)) u_dut (
        .clk(clk), .reset(reset), .issue(issue), .issue_ready(issue_ready),
        .res(res), .apb_req(apb_req), .apb_rsp(apb_rsp));

    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Hang guard, far above the few hundred cycles needed
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            $display("ERROR at %0t: run did not finish", $time);
            end_of_test();
        end
    end

    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; request held until pready is sampled high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
        @(posedge clk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
        @(posedge clk);
        apb_req.penable <= 1'b1;
        do @(posedge clk); while (apb_rsp.pready !== 1'b1);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req <= '0;
    endtask

    // Issue one branch, work out the outcome and cost, compare the result
    task automatic br(input logic [1:0] imm_d, input logic [3:0] cc, input logic [31:0] cmp,
                      input logic [31:0] off, input logic [2:0] pfx_pv_pt);
        logic [31:0] instr;
        logic [31:0] step;
        logic [31:0] exp_pc;
        logic        ok;
        logic        tk;
        logic        miss;
        logic        is_imm;
        logic [3:0]  cost;
        int          n;
        is_imm = imm_d[1];
        // Immediate form carries the literal, register form the offset index
        instr = {is_imm ? `ZCB_OPC_IMM : `ZCB_OPC_REG, imm_d[0], cc, 5'h13, is_imm ? off[15:0] : 16'h5000};
        ok = (cc == `ZCB_CC_EQ) || (cc == `ZCB_CC_GE) || (cc == `ZCB_CC_GT && !is_imm);
        // Signed compare against zero
        tk = ok && ((cc == `ZCB_CC_EQ) ? (cmp == 32'h0) : (cc == `ZCB_CC_GE) ? !cmp[31] : (!cmp[31] && cmp != 32'h0));
        step = (!is_imm || pfx_pv_pt[2]) ? off : {{16{off[15]}}, off[15:0]};
        exp_pc = tk ? 32'h0001_0F00 + step : 32'h0001_0F00 + `ZCB_PC_STEP;
        miss = ok && is_imm && pfx_pv_pt[1] && (pfx_pv_pt[0] != tk);
        if (ok && is_imm && pfx_pv_pt[1] && !miss) cost = 4'h1;
        else if (miss) cost = (area == 2'h2) ? 4'h7 : 4'h3;
        else if (!tk) cost = 4'h1;
        else cost = (area == 2'h2) ? (imm_d[0] ? 4'h6 : 4'h7) : (imm_d[0] ? 4'h2 : 4'h3);
        if (cost != 4'h1 && area == 2'h2 && mmu > 2'h1) cost = cost + 4'h2;
        @(posedge clk);
        issue <= '{valid: 1'b1, instr: instr, pc: 32'h0001_0F00, cmp_val: cmp, off_val: off,
                   prefix_valid: pfx_pv_pt[2], prefix_hi: off[31:16], pred_valid: pfx_pv_pt[1],
                   pred_taken: pfx_pv_pt[0]};
        // Offer held until ready is seen high at a rising edge
        do @(posedge clk); while (issue_ready !== 1'b1);
        issue.valid <= 1'b0;
        n = 0;
        do begin
            @(negedge clk);
            n++;
            // Port stalls until the outcome is released
            if (res.valid !== 1'b1) check(issue_ready, 1'b0);   // Stall
        end while (res.valid !== 1'b1);
        check(32'(n), {28'h0, cost});                           // Cost
        check(res.cost, cost);                                  // Reported cost
        check(res.next_pc, exp_pc);                             // Target
        check({res.taken, res.unsupported}, {tk, !ok});         // Outcome
        check({res.slot_keep, res.slot_flush}, {tk && imm_d[0], tk && !imm_d[0]}); // Slot
        check({res.imm_form, res.delay, res.cmp_index}, {is_imm, imm_d[0], 5'h13}); // Fields
        if (!is_imm) check(res.off_index, 5'h0A);               // Offset field
        check(res.mispredict, miss);                            // Prediction
        if (tk) n_taken++;
        last_pc = exp_pc;
        last_status = {20'h0, cost, 3'h0, !ok, miss, imm_d[0], tk, 1'b0};
    endtask

    // Verdict and end of run
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        reset = 1'b1;
        issue = '0;
        apb_req = '0;
        n_taken = 32'h0;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        @(negedge clk);
        check(issue_ready, 1'b1);                                // Idle after reset
        apb(1'b0, `ZCB_REG_COUNT, 32'h0);
        check(rd, 32'h0);                                        // No branches yet
        apb(1'b0, 12'h010, 32'h0);
        check(err, 1'b1);                                        // Unmapped error
        check(rd, 32'h0);                                        // Unmapped read
        $display("Reset and map test done");
        for (int i = 0; i < 5; i++) begin
            area = area_t[i];
            mmu = mmu_t[i];
            apb(1'b1, `ZCB_REG_CTRL, {26'h0, mmu, 2'h0, area});
            apb(1'b0, `ZCB_REG_CTRL, 32'h0);
            check(rd & 32'h0000_0033, {26'h0, mmu, 2'h0, area}); // Config
            br(2'b01, `ZCB_CC_EQ, 32'h0,         32'h0000_0100, 3'b000);
            br(2'b00, `ZCB_CC_EQ, 32'h0000_0001, 32'h0000_0100, 3'b000);
            br(2'b00, `ZCB_CC_GE, 32'h0,         32'hFFFF_FF00, 3'b000);
            br(2'b01, `ZCB_CC_GE, 32'h8000_0000, 32'h0000_0040, 3'b000);
            br(2'b01, `ZCB_CC_GT, 32'h0,         32'h0000_0040, 3'b000);
            br(2'b00, `ZCB_CC_GT, 32'h7FFF_FFFF, 32'h0000_0080, 3'b000);
            br(2'b10, `ZCB_CC_EQ, 32'h0,         32'h0000_FFF0, 3'b000);
            br(2'b11, `ZCB_CC_GE, 32'hFFFF_FFFF, 32'h0000_0010, 3'b000);
            br(2'b10, `ZCB_CC_GE, 32'h0000_0005, 32'h0001_8000, 3'b111);
            br(2'b11, `ZCB_CC_EQ, 32'h0000_0003, 32'h0000_0020, 3'b011);
            br(2'b10, `ZCB_CC_EQ, 32'h0,         32'h0000_0020, 3'b010);
            br(2'b10, `ZCB_CC_GT, 32'h0000_0001, 32'h0000_0020, 3'b000);
            // Read-only status must ignore the write
            apb(1'b1, `ZCB_REG_STATUS, 32'hFFFF_FFFF);
            check(err, 1'b0);                                    // Read-only write no error
            apb(1'b0, `ZCB_REG_STATUS, 32'h0);
            check(rd & 32'h0000_0F1F, last_status);              // Status
            apb(1'b0, `ZCB_REG_TARGET, 32'h0);
            check(rd, last_pc);                                  // Last target
            apb(1'b0, `ZCB_REG_COUNT, 32'h0);
            check(rd, n_taken);                                  // Taken count
            $display("Configuration %0d test done", i);
        end
        end_of_test();
    end
endmodule
